// ===== logic/bro_pkg.sv
// Constants, types and register map for the brown-out reset control block
package bro_pkg;

	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] BRO_CTRL_OFFS = 8'h00;
	localparam logic [7:0] BRO_PWR_OFFS = 8'h04;

	// Control register fields
	localparam int BRO_SWEN_BIT = 7;
	localparam int BRO_FAST_BIT = 6;
	localparam int BRO_RDY_BIT = 0;
	localparam int BRO_RSVD_HI = 5;
	localparam int BRO_RSVD_LO = 1;
	// Power control register field
	localparam int BRO_FLAG_BIT = 0;

	// Values loaded at power-on reset; the control bits are also reloaded at brown-out reset
	localparam logic BRO_SWEN_RST = 1'b1;
	localparam logic BRO_FAST_RST = 1'b0;
	localparam logic BRO_FLAG_RST = 1'b0;

	// Bus responses
	localparam logic [1:0] BRO_RESP_OKAY = 2'h0;
	localparam logic [1:0] BRO_RESP_SLVERR = 2'h2;

	// Power-up timer delay
	localparam int BRO_CLK_MHZ = 125;
	localparam int BRO_PWRT_NS = 1000;
	localparam int BRO_PWRT_CYC = (BRO_PWRT_NS * BRO_CLK_MHZ + 999) / 1000;

	// Brown-out mode field from configuration memory
	typedef enum logic [1:0] {
		BRO_MODE_OFF = 2'b00,
		BRO_MODE_SW = 2'b01,
		BRO_MODE_NOSLEEP = 2'b10,
		BRO_MODE_ON = 2'b11
	} bro_mode_e;

	// Power-up sequence states
	typedef enum logic [1:0] {
		BRO_ST_HOLD = 2'b00,
		BRO_ST_TIMER = 2'b01,
		BRO_ST_RUN = 2'b10
	} bro_seq_e;

	// Analog detector indications, bundled for synchronising
	typedef struct packed {
		logic std_low;
		logic lp_low;
		logic std_active;
	} bro_det_s;

endpackage : bro_pkg

// ===== logic/bro_reset_ctrl.sv
// Brown-out reset control: mode decode, control registers, reset hold, power-up timer
`timescale 1ns/10ps
module bro_reset_ctrl
	import bro_pkg::*;
#(
	parameter int PWRT_CYCLES = BRO_PWRT_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Configuration memory, same clock domain
	input wire logic [1:0] brownout_mode_cfg,
	input wire logic low_power_brownout_cfg_n,
	input wire logic powerup_timer_enable_n,
	input wire logic sleep_mode,
	// Analog detectors, asynchronous
	input wire bro_det_s det_async,
	// To analog and core
	output logic brownout_enable,
	output logic bandgap_force_on,
	output logic low_power_brownout_enable,
	output logic reset_hold,
	output logic exec_release
);

	////////////////////////////////////////////////////////////////////////////
	// Detector input synchronisers

	bro_det_s det_s1_q, det_s2_q, det_s3_q, det_q;

	// Three stages; a bit changes once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < $bits(bro_det_s); gi++) begin : g_sync
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					det_s1_q[gi] <= 1'b0;
					det_s2_q[gi] <= 1'b0;
					det_s3_q[gi] <= 1'b0;
					det_q[gi] <= 1'b0;
				end else begin
					det_s1_q[gi] <= det_async[gi];
					det_s2_q[gi] <= det_s1_q[gi];
					det_s3_q[gi] <= det_s2_q[gi];
					if (det_s2_q[gi] == det_s3_q[gi]) begin
						det_q[gi] <= det_s3_q[gi];
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Mode decode

	bro_mode_e mode;
	logic swen_q, fast_q, flag_q, hold_q;
	logic bro_evt;

	assign mode = bro_mode_e'(brownout_mode_cfg);

	// Effective enable is combinational so a mode change acts at once
	always_comb begin
		unique case (mode)
			BRO_MODE_ON: brownout_enable = 1'b1;
			BRO_MODE_NOSLEEP: brownout_enable = ~sleep_mode;
			BRO_MODE_SW: brownout_enable = swen_q;
			BRO_MODE_OFF: brownout_enable = 1'b0;
		endcase
	end

	// Fast start only matters where the detector may be switched off
	assign bandgap_force_on = fast_q &&
		(mode == BRO_MODE_NOSLEEP || mode == BRO_MODE_SW);

	// Erased configuration reads 1, which leaves the detector off
	assign low_power_brownout_enable = ~low_power_brownout_cfg_n;

	////////////////////////////////////////////////////////////////////////////
	// Reset hold and brown-out event

	// Hold while either enabled detector sees undervoltage
	assign reset_hold = (brownout_enable && det_q.std_low) ||
		(low_power_brownout_enable && det_q.lp_low);
	assign bro_evt = reset_hold && !hold_q;

	// Previous hold level for edge detection
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hold_q <= 1'b0;
		end else begin
			hold_q <= reset_hold;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	logic aw_q, w_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic wr_fire, rd_fire, wr_ctrl, wr_pwr;

	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready = !w_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign wr_fire = aw_q && w_q && !bvalid_q;
	assign rd_fire = s_axi_arvalid && !rvalid_q;
	assign wr_ctrl = wr_fire && awaddr_q == BRO_CTRL_OFFS && wstrb_q[0];
	assign wr_pwr = wr_fire && awaddr_q == BRO_PWR_OFFS && wstrb_q[0];

	// Address and data are taken in either order, then combined
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_q <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q <= BRO_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= (awaddr_q == BRO_CTRL_OFFS || awaddr_q == BRO_PWR_OFFS) ?
				BRO_RESP_OKAY : BRO_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read data captured at the same edge that takes the address
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= BRO_RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			rresp_q <= BRO_RESP_OKAY;
			if (s_axi_araddr == BRO_CTRL_OFFS) begin
				rdata_q[BRO_SWEN_BIT] <= swen_q;
				rdata_q[BRO_FAST_BIT] <= fast_q;
				rdata_q[BRO_RDY_BIT] <= det_q.std_active;
			end else if (s_axi_araddr == BRO_PWR_OFFS) begin
				rdata_q[BRO_FLAG_BIT] <= flag_q;
			end else begin
				rresp_q <= BRO_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control and flag registers

	// Bits are writable in every mode, but a brown-out event reload wins over a write; their effect depends on the mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			swen_q <= BRO_SWEN_RST;
			fast_q <= BRO_FAST_RST;
		end else if (bro_evt) begin
			swen_q <= BRO_SWEN_RST;
			fast_q <= BRO_FAST_RST;
		end else if (wr_ctrl) begin
			swen_q <= wdata_q[BRO_SWEN_BIT];
			fast_q <= wdata_q[BRO_FAST_BIT];
		end
	end

	// Shared sticky flag; write 1 clears, a new event wins over the clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flag_q <= BRO_FLAG_RST;
		end else if (bro_evt) begin
			flag_q <= 1'b1;
		end else if (wr_pwr && wdata_q[BRO_FLAG_BIT]) begin
			flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-up sequence

	bro_seq_e seq_q;
	logic [$clog2(PWRT_CYCLES + 1)-1:0] pwrt_cnt_q;

	// Timer restarts on every hold, so a short dip still gets the full delay
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			seq_q <= BRO_ST_HOLD;
			pwrt_cnt_q <= '0;
		end else if (reset_hold) begin
			seq_q <= BRO_ST_HOLD;
			pwrt_cnt_q <= '0;
		end else begin
			unique case (seq_q)
				BRO_ST_HOLD: begin
					pwrt_cnt_q <= '0;
					seq_q <= powerup_timer_enable_n ? BRO_ST_RUN : BRO_ST_TIMER;
				end
				BRO_ST_TIMER: begin
					pwrt_cnt_q <= pwrt_cnt_q + 1'b1;
					if (pwrt_cnt_q == ($bits(pwrt_cnt_q))'(PWRT_CYCLES - 1)) begin
						seq_q <= BRO_ST_RUN;
					end
				end
				BRO_ST_RUN: seq_q <= BRO_ST_RUN;
				default: seq_q <= BRO_ST_HOLD;
			endcase
		end
	end

	assign exec_release = seq_q == BRO_ST_RUN && !reset_hold;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sw_mode_a: assert property (mode == BRO_MODE_SW |-> brownout_enable == swen_q)
		else $error("software mode enable mismatch");
	fixed_mode_a: assert property ((mode == BRO_MODE_ON |-> brownout_enable) and
		(mode == BRO_MODE_OFF |-> !brownout_enable))
		else $error("fixed mode enable wrong");
	sleep_off_a: assert property (mode == BRO_MODE_NOSLEEP |-> brownout_enable != sleep_mode)
		else $error("sleep mode enable wrong");
	fast_gate_a: assert property (bandgap_force_on |-> fast_q && mode[1] != mode[0])
		else $error("band gap forced in wrong mode");
	rsvd_zero_a: assert property (s_axi_rvalid |->
		s_axi_rdata[BRO_RSVD_HI:BRO_RSVD_LO] == 5'h00)
		else $error("reserved bits not zero");
	ready_read_a: assert property (rd_fire && s_axi_araddr == BRO_CTRL_OFFS |=>
		s_axi_rdata[BRO_RDY_BIT] == $past(det_q.std_active))
		else $error("ready bit wrong");
	lp_hold_a: assert property (low_power_brownout_enable && det_q.lp_low |-> reset_hold)
		else $error("low-power undervoltage not held");
	flag_set_a: assert property (bro_evt |=> flag_q)
		else $error("brown-out flag not set");
	evt_load_a: assert property (bro_evt |=> swen_q && !fast_q)
		else $error("control bits not reloaded");
	lp_cfg_a: assert property (low_power_brownout_cfg_n |-> !low_power_brownout_enable)
		else $error("erased config left detector on");
	pwrt_wait_a: assert property ($fell(reset_hold) && !powerup_timer_enable_n
		|-> !exec_release [*2])
		else $error("execution released before timer");
	fast_clear_a: assert property (!fast_q |-> !bandgap_force_on)
		else $error("band gap forced without fast start");
	timer_skip_a: assert property ($fell(reset_hold) && powerup_timer_enable_n
		|=> exec_release || reset_hold)
		else $error("execution not released without timer");

	evt_c: cover property (bro_evt);
	sw_toggle_c: cover property (mode == BRO_MODE_SW && $fell(brownout_enable));
	release_c: cover property ($rose(exec_release));
	set_clear_c: cover property (bro_evt && wr_pwr);

endmodule : bro_reset_ctrl

// ===== sim/bro_det_model.sv
// Behavioural model of the analog standard and low-power voltage detectors
`timescale 1ns/10ps
module bro_det_model
	import bro_pkg::*;
(
	input wire logic std_uv,
	input wire logic lp_uv,
	input wire logic std_on,
	output bro_det_s det
);
	// Comparators settle off the clock grid, so the block must synchronise them
	assign #3 det = {std_uv, lp_uv, std_on};
endmodule : bro_det_model

// ===== sim/bro_reset_ctrl_tb.sv
// Self-checking bench for the brown-out reset control block
`timescale 1ns/10ps
module bro_reset_ctrl_tb
	import bro_pkg::*;
;
	localparam int PW = 4;
	logic sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, lp_cfg_n, pwrt_n, sleep;
	logic std_uv, lp_uv, std_on, bo_en, bg_on, lp_en, hold, run;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, mode;
	bro_det_s det;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	////////////////////////////////////////////////////////////////
	bro_reset_ctrl #(.PWRT_CYCLES(PW)) i_bro_reset_ctrl (.sys_clk(sys_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.brownout_mode_cfg(mode), .low_power_brownout_cfg_n(lp_cfg_n),
		.powerup_timer_enable_n(pwrt_n), .sleep_mode(sleep), .det_async(det),
		.brownout_enable(bo_en), .bandgap_force_on(bg_on),
		.low_power_brownout_enable(lp_en), .reset_hold(hold), .exec_release(run));
	bro_det_model i_bro_det_model (.std_uv(std_uv), .lp_uv(lp_uv), .std_on(std_on), .det(det));
	////////////////////////////////////////////////////////////////
	// Free-running clock
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			$display("[ERR] %0t timeout", $time);
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	////////////////////////////////////////////////////////////////
	// Bus cycles; handshakes are sampled at the rising edge that consumes them
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge sys_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Address and data offered together, each released once taken; only the timeout ends a wait
		do begin
			@(posedge sys_clk);
			if (!ta && awready) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (!tw && wready) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1);
		chk(32'(bresp), 32'(er), "bresp");
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic t;
		t = 1'b0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		// Data and response taken at the edge that shows rvalid high
		do begin
			@(posedge sys_clk);
			if (!t && arready) begin
				t = 1'b1;
				arvalid <= 1'b0;
			end
		end while (rvalid !== 1'b1);
		chk(rdata, ed, "rdata");
		chk(32'(rresp), 32'(er), "rresp");
		rready <= 1'b0;
	endtask : rd
	// Cycles from hold falling to execution release
	task automatic rel_count(input int exp);
		int n;
		for (n = 0; n < 50 && hold !== 1'b0; n++) @(negedge sys_clk);
		for (n = 0; n < 50 && run !== 1'b1; n++) @(negedge sys_clk);
		chk(32'(n), 32'(exp), "release delay");
	endtask : rel_count
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		repeat (8) @(posedge sys_clk);
		rd(BRO_CTRL_OFFS, 32'h81, BRO_RESP_OKAY);
		rd(BRO_PWR_OFFS, 32'h00, BRO_RESP_OKAY);
		wr(BRO_CTRL_OFFS, 32'hFF, BRO_RESP_OKAY);
		rd(BRO_CTRL_OFFS, 32'hC1, BRO_RESP_OKAY);
		wr(8'h08, 32'h00, BRO_RESP_SLVERR);
		rd(BRO_CTRL_OFFS, 32'hC1, BRO_RESP_OKAY);
		rd(8'h08, 32'h00, BRO_RESP_SLVERR);
		std_on <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rd(BRO_CTRL_OFFS, 32'hC0, BRO_RESP_OKAY);
		std_on <= 1'b1;
		$display("test regs done");
	endtask : t_regs
	// Every mode, sleep state and control bit pair
	task automatic t_modes();
		logic ee, eb;
		for (int w = 0; w < 2; w++) for (int f = 0; f < 2; f++) begin
			wr(BRO_CTRL_OFFS, 32'(w * 128 + f * 64), BRO_RESP_OKAY);
			for (int m = 0; m < 4; m++) for (int s = 0; s < 2; s++) begin
				@(posedge sys_clk);
				mode <= 2'(m);
				sleep <= s[0];
				@(negedge sys_clk);
				ee = (m == 3) || (m == 2 && s == 0) || (m == 1 && w == 1);
				eb = (f == 1) && (m == 1 || m == 2);
				chk(32'(bo_en), 32'(ee), "enable");
				chk(32'(bg_on), 32'(eb), "bandgap");
			end
		end
		$display("test modes done");
	endtask : t_modes
	task automatic t_std();
		wr(BRO_CTRL_OFFS, 32'h00, BRO_RESP_OKAY);
		mode <= 2'b01;
		sleep <= 1'b0;
		pwrt_n <= 1'b0;
		std_uv <= 1'b1;
		repeat (8) @(negedge sys_clk);
		chk(32'(hold), 32'h0, "hold while disabled");
		@(posedge sys_clk);
		mode <= 2'b11;
		@(negedge sys_clk);
		chk(32'(hold), 32'h1, "hold on low supply");
		@(posedge sys_clk);
		std_uv <= 1'b0;
		rel_count(PW + 1);
		rd(BRO_PWR_OFFS, 32'h01, BRO_RESP_OKAY);
		wr(BRO_PWR_OFFS, 32'h01, BRO_RESP_OKAY);
		rd(BRO_PWR_OFFS, 32'h00, BRO_RESP_OKAY);
		$display("test standard detector done");
	endtask : t_std
	task automatic t_lp();
		mode <= 2'b00;
		pwrt_n <= 1'b1;
		lp_uv <= 1'b1;
		repeat (8) @(negedge sys_clk);
		chk(32'(hold), 32'h0, "erased detector");
		chk(32'(lp_en), 32'h0, "lp enable");
		wr(BRO_CTRL_OFFS, 32'h40, BRO_RESP_OKAY);
		lp_cfg_n <= 1'b0;
		@(negedge sys_clk);
		chk(32'(lp_en), 32'h1, "lp enable");
		chk(32'(hold), 32'h1, "lp hold");
		@(posedge sys_clk);
		lp_uv <= 1'b0;
		rel_count(1);
		rd(BRO_CTRL_OFFS, 32'h81, BRO_RESP_OKAY);
		rd(BRO_PWR_OFFS, 32'h01, BRO_RESP_OKAY);
		$display("test low-power detector done");
	endtask : t_lp
	// Mid-run power-on reset restores the control bits and clears the flag
	task automatic t_rst();
		wr(BRO_CTRL_OFFS, 32'h40, BRO_RESP_OKAY);
		rst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk(32'(run), 32'h0, "held at release");
		@(negedge sys_clk);
		chk(32'(run), 32'h1, "release after reset");
		repeat (8) @(posedge sys_clk);
		rd(BRO_CTRL_OFFS, 32'h81, BRO_RESP_OKAY);
		rd(BRO_PWR_OFFS, 32'h00, BRO_RESP_OKAY);
		$display("test reset done");
	endtask : t_rst
	////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		mode = 2'b11;
		lp_cfg_n = 1'b1;
		pwrt_n = 1'b1;
		sleep = 1'b0;
		std_uv = 1'b0;
		lp_uv = 1'b0;
		std_on = 1'b1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs();
		t_modes();
		t_std();
		t_lp();
		t_rst();
		print_verdict();
	end
endmodule : bro_reset_ctrl_tb
